//--- verilog/accel_readout_pkg.sv
package accel_readout_pkg;

  // geometry
  localparam int unsigned AXES      = 3;
  localparam int unsigned SAMPLE_W  = 12;
  localparam int unsigned USER_REGS = 3;

  // register offsets
  localparam logic [7:0] ADDR_PART_IDENTITY   = 8'h00;
  localparam logic [7:0] ADDR_RESERVED_ONE    = 8'h01;
  localparam logic [7:0] ADDR_X_SAMPLE_LOW    = 8'h02;
  localparam logic [7:0] ADDR_X_SAMPLE_HIGH   = 8'h03;
  localparam logic [7:0] ADDR_AXIS_STRIDE     = 8'h02;
  localparam logic [7:0] ADDR_MOTION_EVENT    = 8'h09;
  localparam logic [7:0] ADDR_FIFO_EVENT      = 8'h0A;
  localparam logic [7:0] ADDR_TAP_SLOPE       = 8'h0B;
  localparam logic [7:0] ADDR_FLAT_ORIENT     = 8'h0C;
  localparam logic [7:0] ADDR_RESERVED_13     = 8'h0D;
  localparam logic [7:0] ADDR_QUEUE_FILL      = 8'h0E;
  localparam logic [7:0] ADDR_MEASURE_SPAN    = 8'h0F;
  localparam logic [7:0] ADDR_FILTER_WIDTH    = 8'h10;
  localparam logic [7:0] ADDR_POWER_STATE     = 8'h12;
  localparam logic [7:0] ADDR_READOUT_CONTROL = 8'h13;
  localparam logic [7:0] ADDR_SOFT_RESET      = 8'h14;
  localparam logic [7:0] ADDR_USER_BASE       = 8'h38;

  // reset values
  localparam logic [7:0] RST_MEASURE_SPAN    = 8'h03;
  localparam logic [7:0] RST_FILTER_WIDTH    = 8'h0F;
  localparam logic [7:0] RST_POWER_STATE     = 8'h00;
  localparam logic [7:0] RST_READOUT_CONTROL = 8'h00;
  localparam logic [7:0] RST_USER            = 8'h00;
  localparam logic [7:0] RST_RESERVED_13     = 8'hFF;
  localparam logic [7:0] READ_ZERO           = 8'h00;

  // field positions
  localparam int unsigned FRESH_BIT       = 0;
  localparam int unsigned LOW_NIBBLE_LSB  = 4;
  localparam int unsigned DEEP_SLEEP_BIT  = 5;
  localparam int unsigned LOCK_OFF_BIT    = 6;
  localparam int unsigned SPAN_W          = 4;
  localparam int unsigned FILTER_W        = 5;

  // readout availability, one-hot
  typedef enum logic [2:0] {
    RS_POWERUP = 3'b001,
    RS_ACTIVE  = 3'b010,
    RS_DEEP    = 3'b100
  } readState_t;

  // register access from the serial engine
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } regReq_t;

  typedef logic [AXES-1:0][SAMPLE_W-1:0] axisSample_t;

  // event bytes produced elsewhere
  typedef struct packed {
    logic [7:0] motion;
    logic [7:0] fifoEvent;
    logic [7:0] tapSlope;
    logic [7:0] flatOrient;
    logic [7:0] queueFill;
  } eventStatus_t;

  // configuration driven to the rest of the sensor
  typedef struct packed {
    logic [SPAN_W-1:0]   span;
    logic [FILTER_W-1:0] filter;
    logic [7:0]          power;
    logic                lockOff;
  } cfg_t;

endpackage : accel_readout_pkg

//--- verilog/accel_data_register_readout.sv
`timescale 1ns/100ps
// Operation
// - reading X low with the lock on freezes X high until X high is read.
// - a burst read running low then high yields a consistent sample while the lock is on.
// - samples read valid at any time except during power-up or deep sleep.
// - X low bits 7 to 4 hold sample bits 3 to 0.
// - each high register holds sample bits 11 to 4.
// - X low bit 0 reads one when a new sample was taken since X low was last read, else zero.
// - user registers start at zero and take any written value.
// - user registers keep their contents over soft reset and wake from deep sleep.
// - address zero always returns the fixed identity code and ignores writes.
module accel_data_register_readout
  import accel_readout_pkg::*;
#(
  // arbitrary identity value
  parameter logic [7:0] IDENTITY_FIELD = 8'h5C,
  // arbitrary soft reset key
  parameter logic [7:0] SOFT_RESET_KEY = 8'h5A
)(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire regReq_t      regReq,
  output logic [7:0]        rdData,
  output logic              rdValid,
  input  wire logic         sampleValid,
  input  wire axisSample_t  sampleIn,
  input  wire eventStatus_t eventIn,
  input  wire logic         powerUpDone,
  output cfg_t              cfgOut,
  output logic              dataReady
);

  readState_t               state_q;
  readState_t               state_d;
  axisSample_t              live_q;
  logic [AXES-1:0][7:0]     high_q;
  logic [AXES-1:0]          lock_q;
  logic [AXES-1:0]          fresh_q;
  logic [AXES-1:0]          lowRead;
  logic [AXES-1:0]          highRead;
  logic [SPAN_W-1:0]        span_q;
  logic [FILTER_W-1:0]      filter_q;
  logic [7:0]               power_q;
  logic [7:0]               readCtl_q;
  logic [USER_REGS-1:0][7:0] user_q;
  logic [7:0]               rdData_d;
  logic [7:0]               rdData_q;
  logic                     rdValid_q;
  logic                     sampleTake;
  logic                     lockOff;
  logic                     powerWrite;
  logic                     wakeUp;
  logic                     softReset;
  logic                     commonClear;
  logic                     writeOpen;
  // address of an axis low register
  function automatic logic [7:0] lowAddr(input int unsigned idx);
    lowAddr = ADDR_X_SAMPLE_LOW + 8'(idx) * ADDR_AXIS_STRIDE;
  endfunction : lowAddr
  // address of an axis high register
  function automatic logic [7:0] highAddr(input int unsigned idx);
    highAddr = ADDR_X_SAMPLE_HIGH + 8'(idx) * ADDR_AXIS_STRIDE;
  endfunction : highAddr

  // write strobe for one address
  function automatic logic writeHit(input regReq_t req, input logic [7:0] addr);
    writeHit = req.wr && (req.addr == addr);
  endfunction : writeHit

  assign lockOff     = readCtl_q[LOCK_OFF_BIT];
  assign powerWrite  = writeHit(regReq, ADDR_POWER_STATE);
  assign wakeUp      = powerWrite && (state_q == RS_DEEP) && !regReq.wdata[DEEP_SLEEP_BIT];
  assign writeOpen   = (state_q != RS_DEEP);
  assign softReset   = writeOpen && writeHit(regReq, ADDR_SOFT_RESET) && (regReq.wdata == SOFT_RESET_KEY);
  assign commonClear = softReset || wakeUp;
  assign sampleTake  = sampleValid && (state_q == RS_ACTIVE);
  always_comb
  begin
    for (int i = 0; i < AXES; i++)
    begin
      lowRead[i]  = regReq.rd && (regReq.addr == lowAddr(i));
      highRead[i] = regReq.rd && (regReq.addr == highAddr(i));
    end
  end

  // availability state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RS_POWERUP:
      begin
        if (powerUpDone)
        begin
          state_d = RS_ACTIVE;
        end
      end
      RS_ACTIVE:
      begin
        if (powerWrite && regReq.wdata[DEEP_SLEEP_BIT])
        begin
          state_d = RS_DEEP;
        end
      end
      RS_DEEP:
      begin
        if (wakeUp)
        begin
          state_d = RS_POWERUP;
        end
      end
      default:
      begin
        state_d = RS_POWERUP;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= RS_POWERUP;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
    end
  end

  // live sample capture
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      live_q <= '0;
    end
    else if (clkEn && sampleTake)
    begin
      live_q <= sampleIn;
    end
  end

  // high byte shadow per axis
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      high_q <= '0;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < AXES; i++)
      begin
        // frozen while locked or on the low read, unless lockOff is set
        if (lockOff || (!lock_q[i] && !lowRead[i]))
        begin
          high_q[i] <= sampleTake ? sampleIn[i][SAMPLE_W-1:LOW_NIBBLE_LSB] : live_q[i][SAMPLE_W-1:LOW_NIBBLE_LSB];
        end
      end
    end
  end

  // lock per axis
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lock_q <= '0;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < AXES; i++)
      begin
        if (lockOff)
        begin
          lock_q[i] <= 1'b0;
        end
        // low then high in a burst locks then releases
        else if (lowRead[i])
        begin
          lock_q[i] <= 1'b1;
        end
        else if (highRead[i])
        begin
          lock_q[i] <= 1'b0;
        end
      end
    end
  end

  // fresh-data flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fresh_q <= '0;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < AXES; i++)
      begin
        // new sample wins over the read clear
        if (sampleTake)
        begin
          fresh_q[i] <= 1'b1;
        end
        else if (lowRead[i])
        begin
          fresh_q[i] <= 1'b0;
        end
      end
    end
  end

  // common registers revert on reset, soft reset and wake
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      span_q    <= RST_MEASURE_SPAN[SPAN_W-1:0];
      filter_q  <= RST_FILTER_WIDTH[FILTER_W-1:0];
      readCtl_q <= RST_READOUT_CONTROL;
    end
    else if (clkEn)
    begin
      if (commonClear)
      begin
        span_q    <= RST_MEASURE_SPAN[SPAN_W-1:0];
        filter_q  <= RST_FILTER_WIDTH[FILTER_W-1:0];
        readCtl_q <= RST_READOUT_CONTROL;
      end
      else if (writeOpen)
      begin
        if (writeHit(regReq, ADDR_MEASURE_SPAN))
        begin
          span_q <= regReq.wdata[SPAN_W-1:0];
        end
        if (writeHit(regReq, ADDR_FILTER_WIDTH))
        begin
          filter_q <= regReq.wdata[FILTER_W-1:0];
        end
        if (writeHit(regReq, ADDR_READOUT_CONTROL))
        begin
          readCtl_q <= regReq.wdata;
        end
      end
    end
  end

  // power control stays writable in deep sleep
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      power_q <= RST_POWER_STATE;
    end
    else if (clkEn)
    begin
      if (wakeUp || softReset)
      begin
        power_q <= RST_POWER_STATE;
      end
      else if (powerWrite)
      begin
        power_q <= regReq.wdata;
      end
    end
  end

  // user registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      user_q <= {USER_REGS{RST_USER}};
    end
    // untouched by soft reset and wake
    else if (clkEn && writeOpen)
    begin
      for (int i = 0; i < USER_REGS; i++)
      begin
        if (writeHit(regReq, ADDR_USER_BASE + 8'(i)))
        begin
          user_q[i] <= regReq.wdata;
        end
      end
    end
  end

  // read multiplexer
  always_comb
  begin
    rdData_d = READ_ZERO;
    for (int i = 0; i < AXES; i++)
    begin
      if (regReq.addr == lowAddr(i))
      begin
        // low nibble on bits 7 to 4, fresh flag on bit 0
        rdData_d = {live_q[i][3:0], 3'h0, fresh_q[i]};
      end
      if (regReq.addr == highAddr(i))
      begin
        rdData_d = high_q[i];
      end
    end
    // no valid sample outside active state
    if (state_q != RS_ACTIVE && regReq.addr >= ADDR_X_SAMPLE_LOW && regReq.addr <= highAddr(AXES - 1))
    begin
      rdData_d = READ_ZERO;
    end
    for (int i = 0; i < USER_REGS; i++)
    begin
      if (regReq.addr == ADDR_USER_BASE + 8'(i))
      begin
        rdData_d = user_q[i];
      end
    end
    case (regReq.addr)
      ADDR_PART_IDENTITY:   rdData_d = IDENTITY_FIELD;
      ADDR_MOTION_EVENT:    rdData_d = eventIn.motion;
      ADDR_FIFO_EVENT:      rdData_d = eventIn.fifoEvent;
      ADDR_TAP_SLOPE:       rdData_d = eventIn.tapSlope;
      ADDR_FLAT_ORIENT:     rdData_d = eventIn.flatOrient;
      ADDR_RESERVED_13:     rdData_d = RST_RESERVED_13;
      ADDR_QUEUE_FILL:      rdData_d = eventIn.queueFill;
      ADDR_MEASURE_SPAN:    rdData_d = {{(8 - SPAN_W){1'b0}}, span_q};
      ADDR_FILTER_WIDTH:    rdData_d = {{(8 - FILTER_W){1'b0}}, filter_q};
      ADDR_POWER_STATE:     rdData_d = power_q;
      ADDR_READOUT_CONTROL: rdData_d = readCtl_q;
      default:              rdData_d = rdData_d;
    endcase
  end

  // registered read answer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdData_q  <= READ_ZERO;
      rdValid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      rdValid_q <= regReq.rd;
      if (regReq.rd)
      begin
        rdData_q <= rdData_d;
      end
    end
  end

  assign rdData       = rdData_q;
  assign rdValid      = rdValid_q;
  assign dataReady    = (state_q == RS_ACTIVE);
  assign cfgOut.span    = span_q;
  assign cfgOut.filter  = filter_q;
  assign cfgOut.power   = power_q;
  assign cfgOut.lockOff = lockOff;
endmodule : accel_data_register_readout

//--- tb/accel_readout_assertions.sv
`timescale 1ns/100ps
module accel_readout_assertions
  import accel_readout_pkg::*;
#(
  parameter logic [7:0] IDENTITY_FIELD = 8'h5C,
  parameter logic [7:0] SOFT_RESET_KEY = 8'h5A
)(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire regReq_t     regReq,
  input wire logic [7:0]  rdData,
  input wire logic        rdValid,
  input wire logic        sampleValid,
  input wire axisSample_t sampleIn,
  input wire cfg_t        cfgOut,
  input wire logic        dataReady
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic rdX;
  logic rdH;
  logic newS;
  assign rdX = clkEn && regReq.rd && regReq.addr == ADDR_X_SAMPLE_LOW;
  assign rdH = clkEn && regReq.rd && regReq.addr == ADDR_X_SAMPLE_HIGH;
  assign newS = clkEn && sampleValid && dataReady;
  read_answer_a: assert property (
    clkEn && regReq.rd |=> rdValid) else $error("read not answered");
  ident_read_a: assert property (
    clkEn && regReq.rd && regReq.addr == ADDR_PART_IDENTITY |=> rdData == IDENTITY_FIELD)
    else $error("identity read wrong");
  idle_zero_a: assert property (
    rdX && !dataReady |=> rdData == READ_ZERO) else $error("sample read while idle");
  low_pad_a: assert property (
    rdX |=> rdData[3:1] == 3'h0) else $error("low pad bits set");
  reset_vals_a: assert property (
    $fell(rst) |-> cfgOut.span == RST_MEASURE_SPAN[3:0] && !dataReady && !rdValid)
    else $error("reset values wrong");
  soft_reset_a: assert property (
    clkEn && regReq.wr && regReq.addr == ADDR_SOFT_RESET && regReq.wdata == SOFT_RESET_KEY && dataReady
    |=> cfgOut.filter == RST_FILTER_WIDTH[4:0] && !cfgOut.lockOff) else $error("soft reset missed");
  fresh_set_a: assert property (
    newS ##1 !rdX ##1 rdX && dataReady |=> rdData[FRESH_BIT]) else $error("fresh flag not set");
  fresh_clear_a: assert property (
    rdX && !newS ##1 (!newS)[*3] ##1 rdX && !newS |=> !rdData[FRESH_BIT]) else $error("fresh flag stuck");
  lock_off_a: assert property (
    newS && cfgOut.lockOff ##1 rdH && !sampleValid && dataReady && cfgOut.lockOff
    |=> rdData == $past(sampleIn[0][11:4], 2)) else $error("high byte stale");
endmodule : accel_readout_assertions

//--- tb/accel_host_model.sv
`timescale 1ns/100ps
module accel_host_model
  import accel_readout_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdData,
  output regReq_t         regReq
);
  initial regReq = '0;
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regReq <= '{a, 1'b0, 1'b1, d};
    @(posedge mclk);
    regReq <= '{~a, 1'b0, 1'b0, ~d};
  endtask : wrReg
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regReq <= '{a, 1'b1, 1'b0, 8'h00};
    @(posedge mclk);
    regReq <= '{~a, 1'b0, 1'b0, 8'hFF};
    @(posedge mclk);
    d = rdData;
  endtask : rdReg
  task automatic readX(output logic [11:0] s, output logic f);
    logic [7:0] lo;
    @(posedge mclk);
    regReq <= '{ADDR_X_SAMPLE_LOW, 1'b1, 1'b0, 8'h00};
    @(posedge mclk);
    regReq.addr <= ADDR_X_SAMPLE_HIGH;
    @(posedge mclk);
    regReq <= '{8'hFC, 1'b0, 1'b0, 8'hFF};
    lo = rdData;
    @(posedge mclk);
    s = {rdData, lo[7:4]};
    f = lo[FRESH_BIT];
  endtask : readX
endmodule : accel_host_model

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import accel_readout_pkg::*;
  // arbitrary values
  localparam logic [7:0] IDF = 8'h5C;
  localparam logic [7:0] KEY = 8'h5A;
  logic         mclk, rst, clkEn, sampleValid, powerUpDone, dataReady, rdValid, f;
  logic [7:0]   rdData, d, v;
  logic [11:0]  s, a, b;
  regReq_t      regReq;
  axisSample_t  sampleIn;
  eventStatus_t eventIn;
  cfg_t         cfgOut;
  int           err_count, checks, seed;
  accel_data_register_readout #(.IDENTITY_FIELD(IDF), .SOFT_RESET_KEY(KEY)) dut (
    .mclk(mclk), .rst(rst), .clkEn(clkEn), .regReq(regReq), .rdData(rdData), .rdValid(rdValid),
    .sampleValid(sampleValid), .sampleIn(sampleIn), .eventIn(eventIn), .powerUpDone(powerUpDone),
    .cfgOut(cfgOut), .dataReady(dataReady));
  accel_host_model host (.mclk(mclk), .rdData(rdData), .regReq(regReq));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask : chk
  task automatic finish_test;
    $display("mismatches=%0d comparisons=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic pulse(input logic [11:0] x);
    @(posedge mclk);
    sampleValid <= 1'b1;
    sampleIn <= {12'h0A5, 12'h05A, x};
    @(posedge mclk);
    sampleValid <= 1'b0;
  endtask : pulse
  function automatic logic [11:0] expX(input logic off, input logic [11:0] lo, input logic [11:0] hi);
    return off ? {hi[11:4], lo[3:0]} : lo;
  endfunction : expX
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
  initial
  begin
    {rst, clkEn, sampleValid, powerUpDone, sampleIn, eventIn} = '0;
    rst = 1'b1;
    clkEn = 1'b1;
    seed = 88;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    host.rdReg(ADDR_PART_IDENTITY, d); chk(d, IDF);
    host.wrReg(ADDR_PART_IDENTITY, 8'h00);
    host.rdReg(ADDR_PART_IDENTITY, d); chk(d, IDF);
    host.rdReg(ADDR_MEASURE_SPAN, d); chk(d, RST_MEASURE_SPAN);
    host.rdReg(ADDR_USER_BASE, d); chk(d, RST_USER);
    pulse(12'h123);
    host.readX(s, f); chk(s, 12'h000);
    @(posedge mclk);
    powerUpDone <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk); chk(dataReady, 1'b1);
    a = 12'h9C3;
    pulse(a);
    host.readX(s, f); chk(s, a);
    chk(f, 1'b1);
    host.readX(s, f); chk(f, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      host.wrReg(ADDR_READOUT_CONTROL, k ? 8'h40 : 8'h00);
      a = 12'($random(seed));
      b = 12'($random(seed));
      pulse(a);
      fork
        pulse(b);
        host.readX(s, f);
      join
      chk(s, expX(k[0], a, b));
    end
    for (int i = 0; i < 12; i++)
    begin
      v = 8'($random(seed));
      a = 12'($random(seed));
      host.wrReg(ADDR_USER_BASE + 8'(i % USER_REGS), v);
      host.rdReg(ADDR_USER_BASE + 8'(i % USER_REGS), d); chk(d, v);
      pulse(a);
      host.readX(s, f); chk(s, a);
      chk(f, 1'b1);
    end
    host.wrReg(ADDR_MEASURE_SPAN, 8'h05);
    host.wrReg(ADDR_FILTER_WIDTH, 8'h1B);
    @(negedge mclk);
    chk({cfgOut.lockOff, cfgOut.filter, cfgOut.span}, {1'b1, 5'h1B, 4'h5});
    host.wrReg(ADDR_SOFT_RESET, KEY);
    @(negedge mclk);
    chk({cfgOut.lockOff, cfgOut.filter, cfgOut.span}, {1'b0, RST_FILTER_WIDTH[4:0], RST_MEASURE_SPAN[3:0]});
    host.rdReg(ADDR_USER_BASE + 8'h02, d); chk(d, v);
    host.wrReg(ADDR_MEASURE_SPAN, 8'h05);
    @(negedge mclk); chk(cfgOut.span, 4'h5);
    host.wrReg(ADDR_POWER_STATE, 8'h20);
    @(negedge mclk);
    chk({dataReady, cfgOut.power}, {1'b0, 8'h20});
    host.readX(s, f); chk(s, 12'h000);
    host.wrReg(ADDR_POWER_STATE, 8'h00);
    @(negedge mclk);
    chk({cfgOut.power, cfgOut.span}, {RST_POWER_STATE, RST_MEASURE_SPAN[3:0]});
    host.rdReg(ADDR_USER_BASE + 8'h02, d); chk(d, v);
    pulse(12'h4B6);
    host.readX(s, f); chk(s, 12'h4B6);
    @(posedge mclk);
    clkEn <= 1'b0;
    pulse(12'h7E1);
    @(posedge mclk);
    clkEn <= 1'b1;
    host.readX(s, f); chk(s, 12'h4B6);
    chk(f, 1'b0);
    finish_test();
  end
endmodule : testbench
bind accel_data_register_readout accel_readout_assertions #(
  .IDENTITY_FIELD(IDENTITY_FIELD), .SOFT_RESET_KEY(SOFT_RESET_KEY)) props (
  .mclk(mclk), .rst(rst), .clkEn(clkEn), .regReq(regReq), .rdData(rdData), .rdValid(rdValid),
  .sampleValid(sampleValid), .sampleIn(sampleIn), .cfgOut(cfgOut), .dataReady(dataReady));
